// [bench/far_station.sv]
`timescale 1ns/1ps
`default_nettype none
module far_station (
   // clock
   input  wire logic       clk_i,
   // receiver events toward the unit
   output logic            frame_end_o,
   output logic [7:0]      status_o,
   output logic            dma_want_o,
   output logic            msg_end_o,
   // transmit fifo fill in bytes
   output logic [5:0]      tx_level_o
);
   // quiet line at time zero
   initial begin
      frame_end_o = 1'b0;
      status_o    = 8'hFF;
      dma_want_o  = 1'b0;
      msg_end_o   = 1'b0;
      tx_level_o  = 6'h00;
   end

   // status valid only in the end cycle, scrambled after so stale data shows
   task automatic frame_end(input logic [7:0] st);
      @(posedge clk_i);
      frame_end_o <= 1'b1;
      status_o    <= st;
      @(posedge clk_i);
      frame_end_o <= 1'b0;
      status_o    <= ~st;
   endtask : frame_end

   task automatic msg_end();
      @(posedge clk_i);
      msg_end_o <= 1'b1;
      @(posedge clk_i);
      msg_end_o <= 1'b0;
   endtask : msg_end

   // receiver asks for dma service while high
   task automatic want(input logic v);
      @(posedge clk_i);
      dma_want_o <= v;
   endtask : want

   // never more than one pool loaded
   task automatic load(input logic [5:0] n);
      @(posedge clk_i);
      tx_level_o <= (n > 6'd32) ? 6'd32 : n;
   endtask : load
endmodule : far_station
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic              clk, rst, psel, penable, pwrite, e;
   logic       [11:0] paddr;
   logic       [31:0] pwdata, d;
   wire  logic [31:0] prdata;
   wire  logic        pready, pslverr, fe, want, me, dreq, cyclic, ack_nr, trun, nostuff;
   wire  logic [7:0]  rst_st, st_data, lead;
   wire  logic [5:0]  lvl;
   wire  logic [9:0]  ev;
   logic       [7:0]  cnt [0:9];
   int                cyc = 1, wr_at, w0, rel_at, n_fail, checked;

   hdlc_command_strobe_unit u_dut (
      .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .RX_FRAME_END_I(fe), .RX_STATUS_I(rst_st), .RX_DMA_WANT_I(want),
      .RX_MSG_END_I(me), .TX_FIFO_LEVEL_I(lvl), .RX_RELEASE_O(ev[0]), .RX_FLUSH_O(ev[1]),
      .SEQ_CLEAR_O(ev[2]), .RX_DMA_REQ_O(dreq), .RX_STATUS_PUSH_O(ev[3]),
      .RX_STATUS_DATA_O(st_data), .TX_FLUSH_O(ev[4]), .TX_START_O(), .TX_FLAG_PREFIX_O(ev[5]),
      .TX_ADDR_CTRL_O(ev[6]), .TX_CRC_END_O(ev[7]), .TX_CYCLIC_O(cyclic),
      .TX_ABORT_BIT_O(ev[8]), .TX_POOL_READY_O(ev[9]), .LEAD_IN_PATTERN_O(lead),
      .LEAD_IN_NO_STUFF_O(nostuff), .ACK_NOT_READY_O(ack_nr), .TIMER_RUN_O(trun)
   );
   far_station u_far (.clk_i(clk), .frame_end_o(fe), .status_o(rst_st), .dma_want_o(want),
                      .msg_end_o(me), .tx_level_o(lvl));

   // clock
   always #25 clk = ~clk;

   // pulse counters, sampled before the edge updates land
   always @(posedge clk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 10; i++) begin
         cnt[i] <= cnt[i] + {7'h00, ev[i]};
      end
      if (ev[0] === 1'b1 && rel_at == 0) begin
         rel_at <= cyc;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [11:0] adr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : adr

   // hold keeps psel up so the next setup follows at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input bit hold);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      d     = prdata;
      e     = pslverr;
      wr_at = cyc;
      if (!hold) begin
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [31:0] v);
      apb(1'b1, adr(idx), v, 1'b0);
   endtask : wr

   // host lets the executing flag drop before the next command
   task automatic cmd(input logic [7:0] v);
      wr(hdlc_cmd_pkg::CMD_IDX, {24'h0, v});
      repeat (4) @(posedge clk);
   endtask : cmd

   // transmitter reset and let the abort run out
   task automatic txr();
      cmd(8'h01);
      repeat (12) @(posedge clk);
   endtask : txr

   task automatic clr();
      @(negedge clk);
      for (int i = 0; i < 10; i++) begin
         cnt[i] = 8'h00;
      end
      rel_at = 0;
      @(posedge clk);
   endtask : clr

   task automatic tally_and_finish();
      if (n_fail == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // watchdog well beyond the expected run
   initial begin
      repeat (6000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      clk     = 1'b0;
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      clr();
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk(lead, 8'h00);
      chk(nostuff, 1'b1);
      chk({cyclic, trun, ack_nr}, 3'h0);
      // lead-in pattern and an unmapped word
      wr(hdlc_cmd_pkg::LEAD_IDX, 32'hA5);
      chk(lead, 8'hA5);
      apb(1'b0, 12'hFFC, 32'h0, 1'b0);
      chk(e, 1'b1);
      // message complete, status read right behind
      clr();
      apb(1'b1, adr(hdlc_cmd_pkg::CMD_IDX), 32'h80, 1'b1);
      w0 = wr_at;
      apb(1'b0, adr(hdlc_cmd_pkg::STATUS_IDX), 32'h0, 1'b0);
      chk(d[hdlc_cmd_pkg::CEC_BIT], 1'b1);
      repeat (4) @(posedge clk);
      chk(cnt[0], 8'h01);
      chk(rel_at - w0 >= 1 && rel_at - w0 <= 2, 1'b1);
      apb(1'b0, adr(hdlc_cmd_pkg::STATUS_IDX), 32'h0, 1'b0);
      chk({e, d[hdlc_cmd_pkg::CEC_BIT]}, 2'b00);
      // receiver reset per mode, combined command
      for (int m = 0; m < 2; m++) begin
         wr(hdlc_cmd_pkg::MODE_IDX, m);
         clr();
         cmd(8'hC0);
         chk({cnt[0], cnt[1]}, 16'h0101);
         chk(cnt[2], (m == 0) ? 8'h01 : 8'h00);
      end
      wr(hdlc_cmd_pkg::MODE_IDX, 0);
      cmd(8'h20);
      chk(ack_nr, 1'b1);
      cmd(8'h00);
      chk(ack_nr, 1'b0);
      // info frame only in auto mode
      for (int m = 1; m >= 0; m--) begin
         wr(hdlc_cmd_pkg::MODE_IDX, m);
         txr();
         clr();
         cmd(8'h04);
         chk(cnt[6] > 8'h00, m == 0);
      end
      // transparent frame, then one closed by message end
      wr(hdlc_cmd_pkg::MODE_IDX, 2);
      txr();
      u_far.load(6'd8);
      clr();
      cmd(8'h08);
      chk(cnt[5] > 8'h00, 1'b1);
      txr();
      u_far.load(6'd4);
      clr();
      cmd(8'h0A);
      repeat (40) @(posedge clk);
      u_far.load(6'd0);
      repeat (40) @(posedge clk);
      chk(cnt[7] > 8'h00, 1'b1);
      // cyclic repeat ended by transmitter reset
      wr(hdlc_cmd_pkg::MODE_IDX, 3);
      txr();
      cmd(8'h0A);
      chk(cyclic, 1'b0);
      txr();
      u_far.load(6'd8);
      cmd(8'h2A);
      chk(cyclic, 1'b1);
      clr();
      txr();
      chk(cyclic, 1'b0);
      chk({cnt[4], cnt[8], cnt[9]}, 24'h010701);
      cmd(8'h10);
      chk(trun, 1'b1);
      wr(hdlc_cmd_pkg::TIMCFG_IDX, 32'h3);
      repeat (2) @(posedge clk);
      chk(trun, 1'b0);
      // receive status captured at frame end
      clr();
      u_far.frame_end(8'hA6);
      repeat (3) @(posedge clk);
      chk({cnt[3], st_data}, 16'h01A6);
      apb(1'b0, adr(hdlc_cmd_pkg::RXSTAT_IDX), 32'h0, 1'b0);
      chk(d[7:0], 8'hA6);
      // dma requests blocked after message end until complete
      wr(hdlc_cmd_pkg::XCOUNT_IDX, 32'h8010);
      u_far.want(1'b1);
      repeat (2) @(posedge clk);
      chk(dreq, 1'b1);
      u_far.msg_end();
      repeat (2) @(posedge clk);
      chk(dreq, 1'b0);
      cmd(8'h80);
      chk(dreq, 1'b1);
      u_far.want(1'b0);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire

// [core/hdlc_cmd_pkg.sv]
package hdlc_cmd_pkg;

   // register word indices: printed 0x20 and 0x21 differ by one, not four, so they are indices
   localparam logic [7:0] CMD_IDX      = 8'h20;
   localparam logic [7:0] LEAD_IDX     = 8'h21;
   localparam logic [7:0] STATUS_IDX   = 8'h22;
   localparam logic [7:0] RXSTAT_IDX   = 8'h23;
   localparam logic [7:0] MODE_IDX     = 8'h24;
   localparam logic [7:0] TIMCFG_IDX   = 8'h25;
   localparam logic [7:0] XCOUNT_IDX   = 8'h26;
   localparam logic [7:0] EVENT_IDX    = 8'h27;

   // command bit positions
   localparam int unsigned RMC_BIT  = 7;
   localparam int unsigned RHR_BIT  = 6;
   localparam int unsigned RNR_BIT  = 5;
   localparam int unsigned STI_BIT  = 4;
   localparam int unsigned XTF_BIT  = 3;
   localparam int unsigned XIF_BIT  = 2;
   localparam int unsigned XME_BIT  = 1;
   localparam int unsigned TRANSMITTER_RESET_CMD_BIT = 0;

   // status bit positions
   localparam int unsigned CEC_BIT   = 2;
   localparam int unsigned XRNR_BIT  = 5;

   // reset values and the repeat command code
   localparam logic [7:0] CMD_RESET    = 8'h00;
   localparam logic [7:0] LEAD_RESET   = 8'h00;
   localparam logic [7:0] REPEAT_CODE  = 8'h2A;

   // mode encodings of the mode register low bits
   localparam logic [1:0] MODE_AUTO   = 2'h0;
   localparam logic [1:0] MODE_NAUTO  = 2'h1;
   localparam logic [1:0] MODE_TRANSP = 2'h2;
   localparam logic [1:0] MODE_EXTTR  = 2'h3;

   // timing: command executes within 2.5 cycles, we use 2
   localparam int unsigned CLK_NS       = 50;
   localparam int unsigned EXEC_LIM_PS  = 125000;
   localparam int unsigned EXEC_CYCLES  = EXEC_LIM_PS / (CLK_NS * 1000);
   localparam int unsigned ABORT_ONES   = 7;
   localparam int unsigned FIFO_BYTES   = 32;

   // decoded command carried to the channel logic
   typedef struct packed {
      logic receive_message_complete_cmd;
      logic receiver_reset_cmd;
      logic rep;
      logic start_timer_cmd;
      logic transmit_transparent_frame_cmd;
      logic transmit_info_frame_cmd;
      logic transmit_message_end_cmd;
      logic transmitter_reset_cmd;
   } cmd_t;

   // transmitter sequencing
   typedef enum logic [4:0] {
      TX_IDLE  = 5'b00001,
      TX_FLAG  = 5'b00010,
      TX_DATA  = 5'b00100,
      TX_CYCL  = 5'b01000,
      TX_ABORT = 5'b10000
   } tx_state_t;

endpackage : hdlc_cmd_pkg

// [core/hdlc_command_strobe_unit.sv]
// Overview of operation
// [R1] message complete frees receive fifo space
// [R2] dma rx requests blocked until message complete
// [R3] receiver reset discards receive data
// [R4] auto mode receiver reset clears counters
// [R5] auto mode ack bit selects RR/RNR
// [R6] code 2A repeats fifo bytes unframed
// [R7] transmitter reset ends cyclic repeat
// [R8] start timer; timer config write stops
// [R9] interrupt mode frame start prefixes flag
// [R10] dma start when 32 bytes or count
// [R11] info frame in auto mode only
// [R12] message end appends crc and flag
// [R13] dma mode ignores message end
// [R14] transmitter reset flushes, sends seven ones
// [R15] transmitter reset completion raises pool ready
// [R16] command executes within 2.5 cycles
// [R17] host polls executing flag before writing
// [R18] lead-in pattern sent msb defined
// [R19] no zero insertion during lead-in
// [R20] receive status updated at frame end
// [R21] receive status stored as last byte
// [R22] host uses stored status byte
// [R23] executing flag reads one while busy
// [R24] host writes up to 32 bytes
// [R25] action bits are one-shot
// [R26] combined bits act as one command
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hdlc_command_strobe_unit #(
   parameter int unsigned FIFO_DEPTH = 32
) (
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RESET_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // receiver side events (same clock)
   input  wire logic        RX_FRAME_END_I,
   input  wire logic [7:0]  RX_STATUS_I,
   input  wire logic        RX_DMA_WANT_I,
   input  wire logic        RX_MSG_END_I,
   // transmit fifo level (same clock)
   input  wire logic [5:0]  TX_FIFO_LEVEL_I,
   // outputs to receiver and fifos
   output logic             RX_RELEASE_O,
   output logic             RX_FLUSH_O,
   output logic             SEQ_CLEAR_O,
   output logic             RX_DMA_REQ_O,
   output logic             RX_STATUS_PUSH_O,
   output logic      [7:0]  RX_STATUS_DATA_O,
   // outputs to transmitter
   output logic             TX_FLUSH_O,
   output logic             TX_START_O,
   output logic             TX_FLAG_PREFIX_O,
   output logic             TX_ADDR_CTRL_O,
   output logic             TX_CRC_END_O,
   output logic             TX_CYCLIC_O,
   output logic             TX_ABORT_BIT_O,
   output logic             TX_POOL_READY_O,
   output logic      [7:0]  LEAD_IN_PATTERN_O,
   output logic             LEAD_IN_NO_STUFF_O,
   output logic             ACK_NOT_READY_O,
   // timer control
   output logic             TIMER_RUN_O
);

   logic [7:0]               cmd_r;
   logic                     cmd_pend_r;
   logic                     cec_r;
   logic [7:0]               lead_r;
   logic [7:0]               rx_stat_r;
   logic [7:0]               mode_r;
   logic [7:0]               timcfg_r;
   logic [15:0]              xcount_r;
   logic                     rnr_r;
   logic                     timer_r;
   logic                     dma_block_r;
   logic                     cyclic_r;
   logic                     pool_rdy_r;
   logic [2:0]               abort_cnt_r;
   logic                     dma_wait_r;
   logic                     pend_xme_r;
   hdlc_cmd_pkg::tx_state_t  tx_r;
   hdlc_cmd_pkg::cmd_t       cmd;
   logic                     wr;
   logic                     rd;
   logic [9:0]               idx;
   logic                     auto_md;
   logic                     dma_md;
   logic                     ext_md;
   logic                     hit;
   logic                     exec;

   // apb decode; word index is byte address over four
   assign idx      = PADDR_I[11:2];
   assign wr       = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd       = PSEL_I & PENABLE_I & ~PWRITE_I;
   assign PREADY_O = 1'b1;
   assign hit      = (idx[9:8] == 2'h0) && (idx[7:0] >= hdlc_cmd_pkg::CMD_IDX)
                     && (idx[7:0] <= hdlc_cmd_pkg::EVENT_IDX);
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
   assign auto_md  = mode_r[1:0] == hdlc_cmd_pkg::MODE_AUTO;
   assign ext_md   = mode_r[1:0] == hdlc_cmd_pkg::MODE_EXTTR;
   assign dma_md   = xcount_r[15];
   assign cmd      = hdlc_cmd_pkg::cmd_t'(cmd_r);
   assign exec     = cmd_pend_r;

   // read mux; write-only registers read as zero
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
         case (PADDR_I[9:2])
            // [R23] executing flag read
            hdlc_cmd_pkg::STATUS_IDX:
               PRDATA_O <= {24'h0, 2'h0, rnr_r, 2'h0, cec_r, 2'h0};
            hdlc_cmd_pkg::RXSTAT_IDX: PRDATA_O <= {24'h0, rx_stat_r};
            hdlc_cmd_pkg::MODE_IDX:   PRDATA_O <= {24'h0, mode_r};
            hdlc_cmd_pkg::TIMCFG_IDX: PRDATA_O <= {24'h0, timcfg_r};
            hdlc_cmd_pkg::XCOUNT_IDX: PRDATA_O <= {16'h0, xcount_r};
            hdlc_cmd_pkg::EVENT_IDX:
               PRDATA_O <= {24'h0, 4'h0, timer_r, cyclic_r, dma_block_r, pool_rdy_r};
            default:                  PRDATA_O <= 32'h0000_0000;
         endcase
      end
   end

   // command capture; a write while busy is dropped, hence the host polls
   // [R25] one-shot command strobe
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         cmd_r      <= hdlc_cmd_pkg::CMD_RESET;
         cmd_pend_r <= 1'b0;
      end else if (wr && idx[7:0] == hdlc_cmd_pkg::CMD_IDX && idx[9:8] == 2'h0
                   && !cec_r) begin
         cmd_r      <= PWDATA_I[7:0];
         cmd_pend_r <= 1'b1;
      end else begin
         cmd_r      <= hdlc_cmd_pkg::CMD_RESET;
         cmd_pend_r <= 1'b0;
      end
   end

   // [R16] busy flag spans write and execute
   // [R23] executing flag while pending
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         cec_r <= 1'b0;
      end else begin
         cec_r <= (wr && idx[7:0] == hdlc_cmd_pkg::CMD_IDX && idx[9:8] == 2'h0
                   && !cec_r) | cmd_pend_r;
      end
   end

   // other writable registers
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         lead_r   <= hdlc_cmd_pkg::LEAD_RESET;
         mode_r   <= 8'h00;
         timcfg_r <= 8'h00;
         xcount_r <= 16'h0000;
      end else if (wr && idx[9:8] == 2'h0) begin
         case (idx[7:0])
            hdlc_cmd_pkg::LEAD_IDX:   lead_r   <= PWDATA_I[7:0];
            hdlc_cmd_pkg::MODE_IDX:   mode_r   <= PWDATA_I[7:0];
            hdlc_cmd_pkg::TIMCFG_IDX: timcfg_r <= PWDATA_I[7:0];
            hdlc_cmd_pkg::XCOUNT_IDX: xcount_r <= PWDATA_I[15:0];
            default:                  lead_r   <= lead_r;
         endcase
      end
   end

   // [R5] acknowledge selection kept as a level
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         rnr_r <= 1'b0;
      end else if (exec && auto_md) begin
         rnr_r <= cmd.rep;
      end
   end

   // [R8] timer start and stop by config write
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         timer_r <= 1'b0;
      end else if (wr && idx[9:8] == 2'h0 && idx[7:0] == hdlc_cmd_pkg::TIMCFG_IDX) begin
         timer_r <= 1'b0;
      end else if (exec && cmd.start_timer_cmd) begin
         timer_r <= 1'b1;
      end
   end

   // [R2] rx dma gate; end event sets, message complete clears, set wins
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         dma_block_r <= 1'b0;
      end else if (RX_MSG_END_I && dma_md) begin
         dma_block_r <= 1'b1;
      end else if (exec && (cmd.receive_message_complete_cmd || cmd.receiver_reset_cmd)) begin
         dma_block_r <= 1'b0;
      end
   end

   // [R20] status captured at frame end
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         rx_stat_r        <= 8'h00;
         RX_STATUS_PUSH_O <= 1'b0;
         RX_STATUS_DATA_O <= 8'h00;
      end else begin
         // [R21] copy pushed as final fifo byte
         RX_STATUS_PUSH_O <= RX_FRAME_END_I;
         if (RX_FRAME_END_I) begin
            rx_stat_r        <= RX_STATUS_I;
            RX_STATUS_DATA_O <= RX_STATUS_I;
         end
      end
   end

   // transmit sequencer; combined bits handled in one pass
   // [R26] combined command evaluation
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         tx_r        <= hdlc_cmd_pkg::TX_IDLE;
         cyclic_r    <= 1'b0;
         abort_cnt_r <= 3'h0;
         dma_wait_r  <= 1'b0;
         pend_xme_r  <= 1'b0;
      end else if (exec && cmd.transmitter_reset_cmd) begin
         // [R7] reset overrides repeat
         // [R14] flush and abort ones
         tx_r        <= hdlc_cmd_pkg::TX_ABORT;
         cyclic_r    <= 1'b0;
         abort_cnt_r <= 3'(hdlc_cmd_pkg::ABORT_ONES - 1);
         dma_wait_r  <= 1'b0;
         pend_xme_r  <= 1'b0;
      end else begin
         case (tx_r)
            hdlc_cmd_pkg::TX_IDLE: begin
               // [R6] repeat code in extended transparent mode only
               if (exec && ext_md && cmd_r == hdlc_cmd_pkg::REPEAT_CODE) begin
                  tx_r     <= hdlc_cmd_pkg::TX_CYCL;
                  cyclic_r <= 1'b1;
               // [R11] info frame only in auto mode
               end else if (exec && (cmd.transmit_transparent_frame_cmd || (cmd.transmit_info_frame_cmd && auto_md))) begin
                  tx_r       <= dma_md ? hdlc_cmd_pkg::TX_DATA : hdlc_cmd_pkg::TX_FLAG;
                  dma_wait_r <= dma_md;
                  // [R13] dma ignores message end
                  pend_xme_r <= cmd.transmit_message_end_cmd && !dma_md;
               end
            end
            hdlc_cmd_pkg::TX_DATA: begin
               // [R10] start at 32 bytes or full count
               if (TX_FIFO_LEVEL_I >= 6'(hdlc_cmd_pkg::FIFO_BYTES)
                   || {10'h0, TX_FIFO_LEVEL_I} >= xcount_r[11:0] + 12'h0
                   && xcount_r[11:0] != 12'h0) begin
                  tx_r       <= hdlc_cmd_pkg::TX_FLAG;
                  dma_wait_r <= 1'b0;
               end
            end
            hdlc_cmd_pkg::TX_FLAG: begin
               // [R12] message end closes frame
               if (exec && cmd.transmit_message_end_cmd && !dma_md) begin
                  pend_xme_r <= 1'b1;
               end
               if (pend_xme_r || dma_md) begin
                  tx_r       <= hdlc_cmd_pkg::TX_IDLE;
                  pend_xme_r <= 1'b0;
               end
            end
            hdlc_cmd_pkg::TX_CYCL: tx_r <= hdlc_cmd_pkg::TX_CYCL;
            hdlc_cmd_pkg::TX_ABORT: begin
               if (abort_cnt_r == 3'h0) begin
                  tx_r <= hdlc_cmd_pkg::TX_IDLE;
               end else begin
                  abort_cnt_r <= abort_cnt_r - 3'h1;
               end
            end
            default: tx_r <= hdlc_cmd_pkg::TX_IDLE;
         endcase
      end
   end

   // [R15] pool ready after abort finishes
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         pool_rdy_r <= 1'b0;
      end else begin
         pool_rdy_r <= (tx_r == hdlc_cmd_pkg::TX_ABORT) && (abort_cnt_r == 3'h0);
      end
   end

   // receive side strobes
   // [R1] release on message complete
   assign RX_RELEASE_O = exec & cmd.receive_message_complete_cmd;
   // [R3] receiver flush
   assign RX_FLUSH_O   = exec & cmd.receiver_reset_cmd;
   // [R4] sequence counters cleared in auto mode
   assign SEQ_CLEAR_O  = exec & cmd.receiver_reset_cmd & auto_md;
   // [R2] request gated by block flag
   assign RX_DMA_REQ_O = RX_DMA_WANT_I & dma_md & ~dma_block_r;

   // transmit side outputs
   assign TX_FLUSH_O       = exec & cmd.transmitter_reset_cmd;
   // [R9] frame start prefixed with flag
   assign TX_START_O       = (tx_r == hdlc_cmd_pkg::TX_FLAG) && !dma_wait_r;
   assign TX_FLAG_PREFIX_O = TX_START_O;
   assign TX_ADDR_CTRL_O   = TX_START_O & auto_md;
   assign TX_CRC_END_O     = (tx_r == hdlc_cmd_pkg::TX_FLAG) & (pend_xme_r | dma_md);
   assign TX_CYCLIC_O      = cyclic_r;
   assign TX_ABORT_BIT_O   = tx_r == hdlc_cmd_pkg::TX_ABORT;
   assign TX_POOL_READY_O  = pool_rdy_r;
   // [R18] lead-in pattern msb first
   assign LEAD_IN_PATTERN_O  = lead_r;
   // [R19] stuffing off during lead-in
   assign LEAD_IN_NO_STUFF_O = 1'b1;
   assign ACK_NOT_READY_O    = rnr_r & auto_md;
   assign TIMER_RUN_O        = timer_r;

   // assertions
   property p_exec_bound;
      @(posedge CLK_I) disable iff (RESET_I)
      $rose(cec_r) |-> ##[1:2] !cec_r;
   endproperty
   a_exec_bound: assert property (p_exec_bound) else $error("busy too long"); // [R16]

   property p_cec_pend;
      @(posedge CLK_I) disable iff (RESET_I)
      cmd_pend_r |-> cec_r;
   endproperty
   a_cec_pend: assert property (p_cec_pend) else $error("busy flag low"); // [R23]

   property p_oneshot;
      @(posedge CLK_I) disable iff (RESET_I)
      cmd_pend_r |=> !cmd_pend_r;
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("command held"); // [R25]

   property p_dma_block;
      @(posedge CLK_I) disable iff (RESET_I)
      dma_block_r |-> !RX_DMA_REQ_O;
   endproperty
   a_dma_block: assert property (p_dma_block) else $error("dma not blocked"); // [R2]

   property p_abort_len;
      @(posedge CLK_I) disable iff (RESET_I)
      (exec && cmd.transmitter_reset_cmd) |=> TX_ABORT_BIT_O [*7];
   endproperty
   a_abort_len: assert property (p_abort_len) else $error("abort short"); // [R14]

   property p_pool;
      @(posedge CLK_I) disable iff (RESET_I)
      (exec && cmd.transmitter_reset_cmd) |-> ##8 TX_POOL_READY_O;
   endproperty
   a_pool: assert property (p_pool) else $error("no pool ready"); // [R15]

   property p_cyc_stop;
      @(posedge CLK_I) disable iff (RESET_I)
      (exec && cmd.transmitter_reset_cmd) |=> !TX_CYCLIC_O;
   endproperty
   a_cyc_stop: assert property (p_cyc_stop) else $error("repeat not ended"); // [R7]

   property p_seq;
      @(posedge CLK_I) disable iff (RESET_I)
      SEQ_CLEAR_O |-> RX_FLUSH_O && auto_md;
   endproperty
   a_seq: assert property (p_seq) else $error("bad counter clear"); // [R4]

   property p_stat;
      @(posedge CLK_I) disable iff (RESET_I)
      RX_FRAME_END_I |=> rx_stat_r == $past(RX_STATUS_I) && RX_STATUS_PUSH_O;
   endproperty
   a_stat: assert property (p_stat) else $error("status not captured"); // [R20]

endmodule : hdlc_command_strobe_unit
`default_nettype wire
